// *** sacr_pkg.sv ***
package sacr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] IRQ_MASK_ADDR   = 7'h1d;
  localparam logic [6:0] MUTE_DEEM_ADDR  = 7'h1e;
  localparam logic [6:0] PREAMBLE_ADDR   = 7'h1f;
  localparam logic [6:0] RX_CS_BASE      = 7'h20;
  localparam logic [6:0] RX_CS_LAST      = 7'h37;
  localparam logic [6:0] TX_CS_BASE      = 7'h38;
  localparam logic [6:0] TX_CS_LAST      = 7'h4f;
  localparam logic [6:0] UB_PTR_ADDR     = 7'h50;
  localparam logic [6:0] UB_DATA_ADDR    = 7'h51;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MASK_SRC_ERR_BIT  = 7;
  localparam int MASK_TX_COLL_BIT  = 6;
  localparam int MASK_TX_UB_BIT    = 5;
  localparam int MASK_TX_CSB_BIT   = 4;
  localparam int MASK_RSVD_BIT     = 3;
  localparam int MASK_RX_UB_BIT    = 2;
  localparam int MASK_RX_CSB_BIT   = 1;
  localparam int MASK_RX_ERR_BIT   = 0;
  localparam int SILENCE_BIT       = 5;
  localparam int DEEM_LSB          = 1;
  localparam int PRO_FLAG_BIT      = 0;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  localparam logic [7:0] MUTE_DEEM_RST = 8'h00;
  localparam logic [7:0] UB_PTR_RST    = 8'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'hf7;
  localparam logic [7:0] MUTE_WR_MASK  = 8'h26;
  localparam int         CS_BYTES      = 24;
  localparam int         UB_DEPTH      = 256;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SACR_DEEM_NONE = 2'b00,
    SACR_DEEM_32K  = 2'b01,
    SACR_DEEM_44K1 = 2'b10,
    SACR_DEEM_48K  = 2'b11
  } sacr_deem_t;

endpackage

// *** sacr_byte_bank.sv ***
`timescale 1ns/100ps
module sacr_byte_bank #(
  parameter int DEPTH = 24,
  parameter int AW    = 5
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_idx_i,
  input  wire logic [7:0]    wr_data_i,
  input  wire logic [AW-1:0] rd_idx_i,
  output logic      [7:0]    rd_data_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (wr_en_i && (int'(wr_idx_i) < DEPTH)) begin
      mem_r[wr_idx_i] <= wr_data_i;
    end
  end

  always_comb begin
    if (int'(rd_idx_i) < DEPTH) begin
      rd_data_o = mem_r[rd_idx_i];
    end else begin
      rd_data_o = 8'h00;
    end
  end

endmodule

// *** sacr_regs.sv ***
// Behaviour
// - Mask bit 7 gates the rate-converter error flag onto the interrupt.
// - Mask bit 6 gates the transmit status copy collision flag.
// - Mask bit 5 gates the transmit user buffer empty flag.
// - Mask bit 4 gates the transmit status block sent flag.
// - Mask bit 2 gates the receive user block arrived flag.
// - Mask bit 1 gates the receive status block flag.
// - Mask bit 0 gates the receiver error flag; bit 3 reserved.
// - Status mismatch flag never raises the interrupt; it has no mask.
// - Bit 5 at 0x1E mutes the transmitter when set.
// - Bits 2:1 at 0x1E select converter de-emphasis: none, 32k, 44.1k, 48k.
// - Bit 3 at 0x1F shows surround CD preamble seen.
// - Bit 2 at 0x1F shows non-audio frames.
// - Bit 1 at 0x1F shows subframe A non-audio.
// - Bit 0 at 0x1F shows subframe B non-audio.
// - Receive channel status is 24 bytes at 0x20 to 0x37.
// - Professional flag lives in bit 0 of the first receive byte.
// - Receive status bytes are host-writable only while status autobuffering.
// - Host-written 24-byte transmit status buffer at 0x38 to 0x4F.
// - While autobuffering, transmitted status comes from the receive buffer.
// - Pointer at 0x50 selects the receive user-bit buffer location.
// - Data port 0x51 reads pointed byte; writable only with user autobuffering.
`timescale 1ns/100ps
module sacr_regs #(
  parameter int CS_DEPTH = sacr_pkg::CS_BYTES,
  parameter int UB_DEPTH = sacr_pkg::UB_DEPTH
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Host register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Interrupt status sources
  input  wire logic       rate_converter_error_flag_i,
  input  wire logic       tx_status_copy_collision_flag_i,
  input  wire logic       tx_user_buffer_empty_flag_i,
  input  wire logic       tx_status_block_sent_flag_i,
  input  wire logic       rx_status_mismatch_flag_i,
  input  wire logic       rx_user_block_arrived_flag_i,
  input  wire logic       rx_status_block_flag_i,
  input  wire logic       receiver_error_flag_i,
  // Preamble detection
  input  wire logic       surround_cd_preamble_seen_i,
  input  wire logic       nonaudio_frame_i,
  input  wire logic       nonaudio_subframe_a_i,
  input  wire logic       nonaudio_subframe_b_i,
  // Autobuffer enables
  input  wire logic       status_autobuffer_i,
  input  wire logic       user_autobuffer_i,
  // Receiver side buffer fill
  input  wire logic       rx_cs_wr_i,
  input  wire logic [4:0] rx_cs_idx_i,
  input  wire logic [7:0] rx_cs_data_i,
  input  wire logic       rx_ub_wr_i,
  input  wire logic [7:0] rx_ub_idx_i,
  input  wire logic [7:0] rx_ub_data_i,
  // Transmitter side status fetch
  input  wire logic [4:0] tx_cs_idx_i,
  output logic      [7:0] tx_cs_data_o,
  // Controls
  output logic            transmitter_silence_o,
  output logic      [1:0] converter_deemphasis_select_o,
  output logic            rx_pro_flag_o,
  output logic            tx_pro_flag_o,
  output logic            irq_o
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] irq_mask_r;
  logic [7:0] mute_deem_r;
  logic [7:0] rx_user_bits_pointer_r;
  logic [7:0] rx_user_bits_mem_r [UB_DEPTH];
  logic [7:0] preamble_r;
  logic [7:0] flags;
  logic       irq_nxt;
  logic [7:0] reg_rdata_nxt;
  logic [7:0] rx_cs_rd;
  logic [7:0] tx_cs_rd;
  logic [7:0] tx_cs_host_rd;
  logic       rx_cs_wr;
  logic [4:0] rx_cs_wr_idx;
  logic [7:0] rx_cs_wr_data;
  logic [4:0] rx_cs_rd_idx;
  logic [4:0] tx_cs_rd_idx;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] sync3_r;

  function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo,
                                    input logic [6:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [4:0] cs_index(input logic [6:0] a, input logic [6:0] base);
    logic [6:0] d;
    d = a - base;
    cs_index = d[4:0];
  endfunction

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_mask_r <= sacr_pkg::IRQ_MASK_RST;
    end else if (reg_wr_i && reg_addr_i == sacr_pkg::IRQ_MASK_ADDR) begin
      irq_mask_r <= reg_wdata_i & sacr_pkg::WRITABLE_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mute_deem_r <= sacr_pkg::MUTE_DEEM_RST;
    end else if (reg_wr_i && reg_addr_i == sacr_pkg::MUTE_DEEM_ADDR) begin
      mute_deem_r <= reg_wdata_i & sacr_pkg::MUTE_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign transmitter_silence_o         = mute_deem_r[sacr_pkg::SILENCE_BIT];
  assign converter_deemphasis_select_o =
    mute_deem_r[sacr_pkg::DEEM_LSB +: 2];

  // ----------------------------------------------------------------
  // Preamble status, pins pass three sync flops and a filter flop
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sync3_r <= 8'h00;
    end else begin
      sync1_r <= {4'h0, surround_cd_preamble_seen_i, nonaudio_frame_i,
                  nonaudio_subframe_a_i, nonaudio_subframe_b_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      preamble_r <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          preamble_r[i] <= sync3_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel status buffers
  // ----------------------------------------------------------------
  always_comb begin
    rx_cs_wr      = rx_cs_wr_i;
    rx_cs_wr_idx  = rx_cs_idx_i;
    rx_cs_wr_data = rx_cs_data_i;
    if (reg_wr_i && status_autobuffer_i &&
        in_range(reg_addr_i, sacr_pkg::RX_CS_BASE, sacr_pkg::RX_CS_LAST)) begin
      rx_cs_wr      = 1'b1;
      rx_cs_wr_idx  = cs_index(reg_addr_i, sacr_pkg::RX_CS_BASE);
      rx_cs_wr_data = reg_wdata_i;
    end
  end

  // Host owns the transmit read port only while it reads; the receive port goes to the transmitter only while autobuffering
  logic host_rx_rd;
  logic host_tx_rd;

  assign host_rx_rd = reg_rd_i &&
                      in_range(reg_addr_i, sacr_pkg::RX_CS_BASE, sacr_pkg::RX_CS_LAST);
  assign host_tx_rd = reg_rd_i &&
                      in_range(reg_addr_i, sacr_pkg::TX_CS_BASE, sacr_pkg::TX_CS_LAST);

  always_comb begin
    rx_cs_rd_idx = cs_index(reg_addr_i, sacr_pkg::RX_CS_BASE);
    if (status_autobuffer_i && !host_rx_rd) begin
      rx_cs_rd_idx = tx_cs_idx_i;
    end
  end

  always_comb begin
    tx_cs_rd_idx = tx_cs_idx_i;
    if (host_tx_rd) begin
      tx_cs_rd_idx = cs_index(reg_addr_i, sacr_pkg::TX_CS_BASE);
    end
  end

  sacr_byte_bank #(.DEPTH(CS_DEPTH), .AW(5)) u_rx_cs (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .wr_en_i   (rx_cs_wr),
    .wr_idx_i  (rx_cs_wr_idx),
    .wr_data_i (rx_cs_wr_data),
    .rd_idx_i  (rx_cs_rd_idx),
    .rd_data_o (rx_cs_rd)
  );

  sacr_byte_bank #(.DEPTH(CS_DEPTH), .AW(5)) u_tx_cs (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .wr_en_i   (reg_wr_i && in_range(reg_addr_i, sacr_pkg::TX_CS_BASE,
                                     sacr_pkg::TX_CS_LAST)),
    .wr_idx_i  (cs_index(reg_addr_i, sacr_pkg::TX_CS_BASE)),
    .wr_data_i (reg_wdata_i),
    .rd_idx_i  (tx_cs_rd_idx),
    .rd_data_o (tx_cs_host_rd)
  );

  assign tx_cs_rd      = status_autobuffer_i ? rx_cs_rd : tx_cs_host_rd;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_cs_data_o <= 8'h00;
    end else begin
      tx_cs_data_o <= tx_cs_rd;
    end
  end

  // Professional flags of the first bytes
  logic [7:0] rx_first_r;
  logic [7:0] tx_first_r;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_first_r <= 8'h00;
    end else if (rx_cs_wr && rx_cs_wr_idx == 5'h0) begin
      rx_first_r <= rx_cs_wr_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_first_r <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == sacr_pkg::TX_CS_BASE) begin
      tx_first_r <= reg_wdata_i;
    end
  end

  assign rx_pro_flag_o = rx_first_r[sacr_pkg::PRO_FLAG_BIT];
  assign tx_pro_flag_o = status_autobuffer_i ? rx_first_r[sacr_pkg::PRO_FLAG_BIT]
                         : tx_first_r[sacr_pkg::PRO_FLAG_BIT];

  // ----------------------------------------------------------------
  // Receive user-bit buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_user_bits_pointer_r <= sacr_pkg::UB_PTR_RST;
    end else if (reg_wr_i && reg_addr_i == sacr_pkg::UB_PTR_ADDR) begin
      rx_user_bits_pointer_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < UB_DEPTH; i++) begin
        rx_user_bits_mem_r[i] <= 8'h00;
      end
    end else if (reg_wr_i && user_autobuffer_i && reg_addr_i == sacr_pkg::UB_DATA_ADDR) begin
      rx_user_bits_mem_r[rx_user_bits_pointer_r] <= reg_wdata_i;
    end else if (rx_ub_wr_i) begin
      rx_user_bits_mem_r[rx_ub_idx_i] <= rx_ub_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  assign flags = {rate_converter_error_flag_i, tx_status_copy_collision_flag_i,
                  tx_user_buffer_empty_flag_i, tx_status_block_sent_flag_i,
                  1'b0, rx_user_block_arrived_flag_i, rx_status_block_flag_i,
                  receiver_error_flag_i};

  always_comb begin
    irq_nxt = 1'b0;
    if (flags[sacr_pkg::MASK_SRC_ERR_BIT] && irq_mask_r[sacr_pkg::MASK_SRC_ERR_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_TX_COLL_BIT] && irq_mask_r[sacr_pkg::MASK_TX_COLL_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_TX_UB_BIT] && irq_mask_r[sacr_pkg::MASK_TX_UB_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_TX_CSB_BIT] && irq_mask_r[sacr_pkg::MASK_TX_CSB_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_RX_UB_BIT] && irq_mask_r[sacr_pkg::MASK_RX_UB_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_RX_CSB_BIT] && irq_mask_r[sacr_pkg::MASK_RX_CSB_BIT]) begin
      irq_nxt = 1'b1;
    end
    if (flags[sacr_pkg::MASK_RX_ERR_BIT] && irq_mask_r[sacr_pkg::MASK_RX_ERR_BIT]) begin
      irq_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    if (reg_addr_i == sacr_pkg::IRQ_MASK_ADDR) begin
      reg_rdata_nxt = irq_mask_r;
    end else if (reg_addr_i == sacr_pkg::MUTE_DEEM_ADDR) begin
      reg_rdata_nxt = mute_deem_r;
    end else if (reg_addr_i == sacr_pkg::PREAMBLE_ADDR) begin
      reg_rdata_nxt = preamble_r;
    end else if (in_range(reg_addr_i, sacr_pkg::RX_CS_BASE, sacr_pkg::RX_CS_LAST)) begin
      reg_rdata_nxt = rx_cs_rd;
    end else if (in_range(reg_addr_i, sacr_pkg::TX_CS_BASE, sacr_pkg::TX_CS_LAST)) begin
      reg_rdata_nxt = tx_cs_host_rd;
    end else if (reg_addr_i == sacr_pkg::UB_PTR_ADDR) begin
      reg_rdata_nxt = rx_user_bits_pointer_r;
    end else if (reg_addr_i == sacr_pkg::UB_DATA_ADDR) begin
      reg_rdata_nxt = rx_user_bits_mem_r[rx_user_bits_pointer_r];
    end else begin
      reg_rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= reg_rdata_nxt;
    end
  end

endmodule

// *** sacr_regs_monitor.sv ***
`timescale 1ns/100ps
module sacr_regs_monitor (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       rate_converter_error_flag_i,
  input wire logic       tx_status_copy_collision_flag_i,
  input wire logic       tx_user_buffer_empty_flag_i,
  input wire logic       tx_status_block_sent_flag_i,
  input wire logic       rx_status_mismatch_flag_i,
  input wire logic       rx_user_block_arrived_flag_i,
  input wire logic       rx_status_block_flag_i,
  input wire logic       receiver_error_flag_i,
  input wire logic       transmitter_silence_o,
  input wire logic [1:0] converter_deemphasis_select_o,
  input wire logic       irq_o
);
  // --------
  // Shadow mask
  // --------
  logic [7:0] mask_r;
  logic [7:0] flags;
  logic       mute_wr;
  assign flags = {rate_converter_error_flag_i, tx_status_copy_collision_flag_i,
                  tx_user_buffer_empty_flag_i, tx_status_block_sent_flag_i, 1'b0,
                  rx_user_block_arrived_flag_i, rx_status_block_flag_i, receiver_error_flag_i};
  assign mute_wr = reg_wr_i && reg_addr_i == sacr_pkg::MUTE_DEEM_ADDR;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mask_r <= sacr_pkg::IRQ_MASK_RST;
    end else if (reg_wr_i && reg_addr_i == sacr_pkg::IRQ_MASK_ADDR) begin
      mask_r <= reg_wdata_i & sacr_pkg::WRITABLE_MASK;
    end
  end
  // --------
  // Assertions
  // --------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  irq_match_a: assert property (
    !$past(rst_i) |-> irq_o == $past(|(flags & mask_r)))
    else $error("irq differs from masked flags");
  src_err_gate_a: assert property (
    mask_r[7] && rate_converter_error_flag_i |=> irq_o)
    else $error("unmasked converter error gave no irq");
  rx_err_gate_a: assert property (!mask_r[0] && flags == 8'h01 |=> !irq_o)
    else $error("masked receiver error raised irq");
  mismatch_quiet_a: assert property (
    rx_status_mismatch_flag_i && flags == 8'h00 |=> !irq_o)
    else $error("mismatch flag raised irq");
  mute_write_a: assert property (
    mute_wr |=> transmitter_silence_o == $past(reg_wdata_i[5]))
    else $error("silence bit not written");
  deem_write_a: assert property (
    mute_wr |=> converter_deemphasis_select_o == $past(reg_wdata_i[2:1]))
    else $error("deemphasis field not written");
  mute_hold_a: assert property (
    !mute_wr |=> $stable({transmitter_silence_o, converter_deemphasis_select_o}))
    else $error("mute controls changed without write");
  mask_read_a: assert property (
    reg_rd_i && reg_addr_i == sacr_pkg::IRQ_MASK_ADDR |=> reg_rdata_o == $past(mask_r))
    else $error("mask readback wrong");
  unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < sacr_pkg::IRQ_MASK_ADDR ||
    reg_addr_i > sacr_pkg::UB_DATA_ADDR) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  cover property ($rose(irq_o));
  cover property (mute_wr);
  cover property (reg_rd_i && reg_addr_i == sacr_pkg::IRQ_MASK_ADDR);
endmodule

bind sacr_regs sacr_regs_monitor sacr_regs_monitor_i (.clock_i, .rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .rate_converter_error_flag_i,
  .tx_status_copy_collision_flag_i, .tx_user_buffer_empty_flag_i, .tx_status_block_sent_flag_i,
  .rx_status_mismatch_flag_i, .rx_user_block_arrived_flag_i, .rx_status_block_flag_i,
  .receiver_error_flag_i, .transmitter_silence_o, .converter_deemphasis_select_o, .irq_o);

// *** sacr_host_model.sv ***
`timescale 1ns/100ps
module sacr_host_model (
  input  wire logic       clock_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [6:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  // --------
  // Host accesses, driven on the falling edge
  // --------
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
endmodule

// *** sacr_regs_tb.sv ***
`timescale 1ns/100ps
module sacr_regs_tb;
  logic       clock_i;
  logic       rst_i;
  logic [7:0] flags;
  logic [3:0] pre;
  logic       sab;
  logic       uab;
  logic       cs_wr;
  logic [4:0] cs_idx;
  logic       ub_wr;
  logic [7:0] ub_idx;
  logic [7:0] ub_data;
  logic [7:0] cs_data;
  logic [4:0] tx_idx;
  logic       reg_wr;
  logic       reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] rdata;
  logic [7:0] tx_data;
  logic       silence;
  logic       rx_pro;
  logic       tx_pro;
  logic       irq;
  logic [1:0] deem;
  logic [7:0] rx_cs_m [24];
  logic [7:0] tx_cs_m [24];
  logic [7:0] ub_m [256];
  logic [7:0] m;
  logic [7:0] d;
  int         fail_count;
  int         checks;

  sacr_host_model sacr_host_model_i (.clock_i(clock_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata));
  sacr_regs sacr_regs_i (.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .rate_converter_error_flag_i(flags[7]), .tx_status_copy_collision_flag_i(flags[6]),
    .tx_user_buffer_empty_flag_i(flags[5]), .tx_status_block_sent_flag_i(flags[4]),
    .rx_status_mismatch_flag_i(flags[3]), .rx_user_block_arrived_flag_i(flags[2]),
    .rx_status_block_flag_i(flags[1]), .receiver_error_flag_i(flags[0]),
    .surround_cd_preamble_seen_i(pre[3]), .nonaudio_frame_i(pre[2]),
    .nonaudio_subframe_a_i(pre[1]), .nonaudio_subframe_b_i(pre[0]),
    .status_autobuffer_i(sab), .user_autobuffer_i(uab), .rx_cs_wr_i(cs_wr),
    .rx_cs_idx_i(cs_idx), .rx_cs_data_i(cs_data), .rx_ub_wr_i(ub_wr), .rx_ub_idx_i(ub_idx),
    .rx_ub_data_i(ub_data), .tx_cs_idx_i(tx_idx), .tx_cs_data_o(tx_data),
    .transmitter_silence_o(silence), .converter_deemphasis_select_o(deem),
    .rx_pro_flag_o(rx_pro), .tx_pro_flag_o(tx_pro), .irq_o(irq));

  always #2.5 clock_i = ~clock_i;

  // --------
  // Checking helpers
  // --------
  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic rd_chk(input string w, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    sacr_host_model_i.read_reg(a, v);
    check(w, v, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(5 * 20000);
    fail_count++;
    report_and_stop();
  end

  // --------
  // Scenarios
  // --------
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    {flags, pre, sab, uab, cs_wr, cs_idx, cs_data, ub_wr, ub_idx, ub_data, tx_idx} = '0;
    fail_count = 0;
    checks = 0;
    void'($urandom(62));
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    for (int i = int'(sacr_pkg::IRQ_MASK_ADDR); i <= int'(sacr_pkg::UB_DATA_ADDR); i++) begin
      rd_chk("reset value", 7'(i), 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      m = (i < 8) ? (8'h01 << i) : 8'($urandom);
      sacr_host_model_i.write_reg(sacr_pkg::IRQ_MASK_ADDR, m);
      rd_chk("mask", sacr_pkg::IRQ_MASK_ADDR, m & sacr_pkg::WRITABLE_MASK);
      flags = (i < 8) ? m : 8'($urandom);
      d = m & flags & sacr_pkg::WRITABLE_MASK;
      repeat (2) @(negedge clock_i);
      check("irq", 8'(irq), 8'(|d));
      flags = ~flags;
      d = m & flags & sacr_pkg::WRITABLE_MASK;
      repeat (2) @(negedge clock_i);
      check("irq inverse", 8'(irq), 8'(|d));
      flags = 8'h00;
    end
    for (int i = 0; i < 8; i++) begin
      m = 8'($urandom);
      m[2:1] = i[1:0];
      sacr_host_model_i.write_reg(sacr_pkg::MUTE_DEEM_ADDR, m);
      rd_chk("mute reg", sacr_pkg::MUTE_DEEM_ADDR, m & sacr_pkg::MUTE_WR_MASK);
      check("silence", 8'(silence), 8'(m[sacr_pkg::SILENCE_BIT]));
      check("deem", 8'(deem), 8'(m[2:1]));
      pre = 4'($urandom);
      repeat (6) @(negedge clock_i);
      sacr_host_model_i.write_reg(sacr_pkg::PREAMBLE_ADDR, 8'hff);
      rd_chk("preamble", sacr_pkg::PREAMBLE_ADDR, {4'h0, pre});
    end
    for (int i = 0; i < 24; i++) begin
      @(negedge clock_i);
      cs_wr = 1'b1;
      cs_idx = 5'(i);
      cs_data = 8'($urandom);
      rx_cs_m[i] = cs_data;
      @(negedge clock_i);
      cs_wr = 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      sab = j[0];
      for (int i = 0; i < 24; i++) begin
        d = 8'($urandom);
        sacr_host_model_i.write_reg(sacr_pkg::RX_CS_BASE + 7'(i), d);
        if (j == 1) rx_cs_m[i] = d;
        if (j == 0) tx_cs_m[i] = ~d;
        if (j == 0) sacr_host_model_i.write_reg(sacr_pkg::TX_CS_BASE + 7'(i), ~d);
        rd_chk("rx status", sacr_pkg::RX_CS_BASE + 7'(i), rx_cs_m[i]);
        rd_chk("tx status", sacr_pkg::TX_CS_BASE + 7'(i), tx_cs_m[i]);
        tx_idx = 5'(i);
        repeat (2) @(negedge clock_i);
        check("tx fetch", tx_data, j ? rx_cs_m[i] : tx_cs_m[i]);
      end
      check("rx pro", 8'(rx_pro), 8'(rx_cs_m[0][0]));
      check("tx pro", 8'(tx_pro), 8'(j ? rx_cs_m[0][0] : tx_cs_m[0][0]));
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_i);
      m = 8'($urandom);
      ub_wr = 1'b1;
      ub_idx = m;
      ub_data = 8'($urandom);
      ub_m[m] = ub_data;
      @(negedge clock_i);
      ub_wr = 1'b0;
      uab = i[0];
      sacr_host_model_i.write_reg(sacr_pkg::UB_PTR_ADDR, m);
      rd_chk("ub pointer", sacr_pkg::UB_PTR_ADDR, m);
      d = 8'($urandom);
      sacr_host_model_i.write_reg(sacr_pkg::UB_DATA_ADDR, d);
      if (uab) ub_m[m] = d;
      rd_chk("ub data", sacr_pkg::UB_DATA_ADDR, ub_m[m]);
    end
    sacr_host_model_i.write_reg(7'h10, 8'hff);
    sacr_host_model_i.write_reg(7'h60, 8'hff);
    rd_chk("unmapped", 7'h10, 8'h00);
    rd_chk("unmapped", 7'h60, 8'h00);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    rd_chk("mask after reset", sacr_pkg::IRQ_MASK_ADDR, sacr_pkg::IRQ_MASK_RST);
    rd_chk("mute after reset", sacr_pkg::MUTE_DEEM_ADDR, sacr_pkg::MUTE_DEEM_RST);
    report_and_stop();
  end
endmodule
